// File: core/rtps_pkg.sv
// Constants for the retimer page-select and shared register bank
`default_nettype none
package rtps_pkg;
   // Register offsets
   localparam logic [7:0] OFS_STRAP_ADDRESS_REPORT   = 8'h00;
   localparam logic [7:0] OFS_VERSION_AND_PART_CODE  = 8'h01;
   localparam logic [7:0] OFS_REF_FREQUENCY_SELECT   = 8'h02;
   localparam logic [7:0] OFS_SHARED_RESERVED_STATUS = 8'h03;
   localparam logic [7:0] OFS_SHARED_RESET_SEQ_CTRL  = 8'h04;
   localparam logic [7:0] OFS_LOAD_STATUS_LOCK_LIMIT = 8'h05;
   localparam logic [7:0] OFS_CHANNEL_SELECT_LOW     = 8'hFC;
   localparam logic [7:0] OFS_CHANNEL_SELECT_HIGH    = 8'hFD;
   localparam logic [7:0] OFS_PAGE_SELECT            = 8'hFF;

   // Page-select fields
   localparam int PAGE_CHAN_BIT  = 0;
   localparam int PAGE_BCAST_BIT = 1;
   localparam logic [1:0] PAGE_SELECT_RESET = 2'h0;
   localparam logic [7:0] SEL_RESET         = 8'h00;

   // Strap address report fields
   localparam int STRAP_LSB = 4;
   localparam logic [6:0] STRAP_ADDR_BASE = 7'h18;

   // Reference frequency field, reset 00 selects 25 MHz
   localparam int REF_SEL_LSB = 5;
   localparam int REF_SEL_MSB = 6;
   localparam logic [7:0] REF_FREQ_RESET = 8'h00;

   // Reset and sequencer control fields
   localparam int DIV_REF_OUT_BIT   = 7;
   localparam int SHARED_RST_BIT    = 6;
   localparam int LOADER_RST_BIT    = 5;
   localparam int LOCK_SEQ_DIS_BIT  = 3;
   localparam logic [7:0] RESET_CTRL_RESET = 8'h01;
   localparam logic [7:0] RESET_CTRL_STORE = 8'h9F;

   // Load status and lock limit fields
   localparam int CRC_TRIGGER_BIT = 6;
   localparam int LOAD_DONE_BIT   = 4;
   localparam int LOCK_LIMIT_LSB  = 0;
   localparam int LOCK_LIMIT_MSB  = 3;
   localparam logic [7:0] LOCK_LIMIT_REG_RESET = 8'h08;
   localparam logic [7:0] LOCK_LIMIT_REG_STORE = 8'hEF;
   localparam logic       LOAD_DONE_RESET      = 1'b1;

   // Read answer for unmapped or ambiguous reads
   localparam logic [7:0] READ_ZERO = 8'h00;
endpackage
`default_nettype wire

// File: core/rtps_chan_route.sv
// Channel routing: write mask and single-channel read decode
`default_nettype none
module rtps_chan_route (
   // Global select registers
   input  wire logic [7:0]  sel_low,
   input  wire logic [7:0]  sel_high,
   input  wire logic [1:0]  page_sel,
   // Routing results
   output logic      [15:0] wr_mask,
   output logic             rd_single,
   output logic      [3:0]  rd_index
);
   // Number of channels selected
   function automatic logic [4:0] count_ones(input logic [15:0] v);
      logic [4:0] cnt;
      cnt = 5'h00;
      for (int i = 0; i < 16; i++)
      begin
         cnt = cnt + {4'h0, v[i]};
      end
      return cnt;
   endfunction

   // Lowest selected channel
   function automatic logic [3:0] first_index(input logic [15:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 15; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   wire logic [15:0] sel_all;
   wire logic        bcast_on;

   assign sel_all  = {sel_high, sel_low};
   // Broadcast only counts while the channel pages are selected
   assign bcast_on = page_sel[rtps_pkg::PAGE_BCAST_BIT] & page_sel[rtps_pkg::PAGE_CHAN_BIT];
   assign wr_mask  = bcast_on ? 16'hFFFF : sel_all;
   // Reads ignore broadcast so one channel can be read back
   assign rd_single = (count_ones(sel_all) == 5'h01);
   assign rd_index  = first_index(sel_all);
endmodule
`default_nettype wire

// File: core/rtps_shared_regs.sv
// Page steering, global select and shared registers of a 16-channel retimer
`default_nettype none
module rtps_shared_regs #(
   parameter logic [2:0] VERSION_CODE = 3'h2,   // Arbitrary value
   parameter logic [4:0] PART_CODE    = 5'h0A   // Arbitrary value
) (
   // Clock, reset and enable
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // Straps and loader status
   input  wire logic [3:0]  addr_strap,
   input  wire logic        eeprom_load_done,
   // Register access port
   input  wire logic [7:0]  acc_addr,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic        acc_wr,
   input  wire logic        acc_rd,
   output logic      [7:0]  acc_rdata,
   output logic             acc_rvalid,
   output logic             acc_busy,
   // Channel page side
   output logic             chan_wr,
   output logic      [15:0] chan_wr_mask,
   output logic             chan_rd,
   output logic      [3:0]  chan_rd_index,
   output logic      [7:0]  chan_addr,
   output logic      [7:0]  chan_wdata,
   input  wire logic [7:0]  chan_rdata,
   // Device controls
   output logic      [6:0]  bus_address,
   output logic      [1:0]  ref_freq_sel,
   output logic             divided_ref_out_select,
   output logic             lock_sequencer_disable,
   output logic      [3:0]  concurrent_lock_limit,
   output logic             shared_page_soft_reset,
   output logic             loader_master_soft_reset,
   output logic             crc_trigger
);
   // Global registers
   logic [7:0] channel_select_low;
   logic [7:0] channel_select_high;
   logic [1:0] page_select;
   // Shared registers
   logic [3:0] strap_code;
   logic       strap_seen;
   logic [7:0] ref_frequency_select;
   logic [7:0] shared_reset_and_sequencer_ctrl;
   logic [7:0] load_status_and_lock_limit;
   logic       load_done;
   // Pending channel read
   logic       rd_pend;

   // Routing decode from the select registers
   wire logic [15:0] route_mask;
   wire logic        route_single;
   wire logic [3:0]  route_index;

   rtps_chan_route u_route (
      .sel_low   (channel_select_low),
      .sel_high  (channel_select_high),
      .page_sel  (page_select),
      .wr_mask   (route_mask),
      .rd_single (route_single),
      .rd_index  (route_index)
   );

   // Address decode; globals win over the page choice
   wire logic hit_sel_low;
   wire logic hit_sel_high;
   wire logic hit_page;
   wire logic hit_global;
   wire logic page_is_chan;
   wire logic to_chan;

   assign hit_sel_low  = (acc_addr == rtps_pkg::OFS_CHANNEL_SELECT_LOW);
   assign hit_sel_high = (acc_addr == rtps_pkg::OFS_CHANNEL_SELECT_HIGH);
   assign hit_page     = (acc_addr == rtps_pkg::OFS_PAGE_SELECT);
   assign hit_global   = hit_sel_low | hit_sel_high | hit_page;
   assign page_is_chan = page_select[rtps_pkg::PAGE_CHAN_BIT];
   assign to_chan      = ~hit_global & page_is_chan;

   // Request acceptance; a write beats a read in the same cycle
   wire logic wr_take;
   wire logic rd_take;

   // Busy blocks both kinds so the held channel address stays put
   assign wr_take = clk_en & acc_wr & ~rd_pend;
   assign rd_take = clk_en & acc_rd & ~acc_wr & ~rd_pend;

   // Shared page write strobes
   wire logic wr_shared;
   wire logic wr_ref;
   wire logic wr_ctrl;
   wire logic wr_limit;
   wire logic shared_rst_req;
   wire logic loader_rst_req;
   wire logic crc_req;

   assign wr_shared      = wr_take & ~hit_global & ~page_is_chan;
   assign wr_ref         = wr_shared & (acc_addr == rtps_pkg::OFS_REF_FREQUENCY_SELECT);
   assign wr_ctrl        = wr_shared & (acc_addr == rtps_pkg::OFS_SHARED_RESET_SEQ_CTRL);
   assign wr_limit       = wr_shared & (acc_addr == rtps_pkg::OFS_LOAD_STATUS_LOCK_LIMIT);
   assign shared_rst_req = wr_ctrl & acc_wdata[rtps_pkg::SHARED_RST_BIT];
   assign loader_rst_req = wr_ctrl & acc_wdata[rtps_pkg::LOADER_RST_BIT];
   assign crc_req        = wr_limit & acc_wdata[rtps_pkg::CRC_TRIGGER_BIT];

   // Shared page read data; reset bits always read back as zero
   wire logic [7:0] strap_view;
   wire logic [7:0] ctrl_view;
   wire logic [7:0] limit_view;
   wire logic [7:0] shared_rdata;
   wire logic [7:0] global_rdata;
   wire logic [7:0] local_rdata;

   // Before the strap is caught, show the pins so an early read is right
   wire logic [3:0] strap_now;
   assign strap_now  = strap_seen ? strap_code : addr_strap;
   assign strap_view = {strap_now, 4'h0};
   assign ctrl_view  = shared_reset_and_sequencer_ctrl & rtps_pkg::RESET_CTRL_STORE;
   assign limit_view = (load_status_and_lock_limit & rtps_pkg::LOCK_LIMIT_REG_STORE)
                       | (8'(load_done) << rtps_pkg::LOAD_DONE_BIT);

   assign shared_rdata =
      (acc_addr == rtps_pkg::OFS_STRAP_ADDRESS_REPORT)   ? strap_view :
      (acc_addr == rtps_pkg::OFS_VERSION_AND_PART_CODE)  ? {VERSION_CODE, PART_CODE} :
      (acc_addr == rtps_pkg::OFS_REF_FREQUENCY_SELECT)   ? ref_frequency_select :
      (acc_addr == rtps_pkg::OFS_LOAD_STATUS_LOCK_LIMIT) ? limit_view :
      (acc_addr == rtps_pkg::OFS_SHARED_RESET_SEQ_CTRL)  ? ctrl_view :
      rtps_pkg::READ_ZERO;

   assign global_rdata =
      hit_sel_low  ? channel_select_low :
      hit_sel_high ? channel_select_high :
      {6'h00, page_select};

   assign local_rdata = hit_global ? global_rdata : shared_rdata;

   // Global select registers, writable from any page
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         channel_select_low  <= rtps_pkg::SEL_RESET;
         channel_select_high <= rtps_pkg::SEL_RESET;
         page_select         <= rtps_pkg::PAGE_SELECT_RESET;
      end
      else if (wr_take)
      begin
         if (hit_sel_low)
            channel_select_low <= acc_wdata;
         if (hit_sel_high)
            channel_select_high <= acc_wdata;
         // Only the two page bits are kept; the rest read as zero
         if (hit_page)
            page_select <= acc_wdata[1:0];
      end
   end

   // Strap caught once after reset release, never under reset itself
   // A strap change after capture is ignored until the next reset
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         strap_seen  <= 1'b0;
         strap_code  <= 4'h0;
         bus_address <= rtps_pkg::STRAP_ADDR_BASE;
      end
      else if (clk_en && !strap_seen)
      begin
         strap_seen  <= 1'b1;
         strap_code  <= addr_strap;
         bus_address <= rtps_pkg::STRAP_ADDR_BASE + {3'h0, addr_strap};
      end
   end

   // Shared writable registers; soft reset overrides the write itself
   // Bits 6 and 5 of the control word are never stored; they act as pulses
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ref_frequency_select            <= rtps_pkg::REF_FREQ_RESET;
         shared_reset_and_sequencer_ctrl <= rtps_pkg::RESET_CTRL_RESET;
         load_status_and_lock_limit      <= rtps_pkg::LOCK_LIMIT_REG_RESET;
      end
      else if (shared_rst_req)
      begin
         ref_frequency_select            <= rtps_pkg::REF_FREQ_RESET;
         shared_reset_and_sequencer_ctrl <= rtps_pkg::RESET_CTRL_RESET;
         load_status_and_lock_limit      <= rtps_pkg::LOCK_LIMIT_REG_RESET;
      end
      else
      begin
         if (wr_ref)
            ref_frequency_select <= acc_wdata;
         if (wr_ctrl)
            shared_reset_and_sequencer_ctrl <= acc_wdata & rtps_pkg::RESET_CTRL_STORE;
         if (wr_limit)
            load_status_and_lock_limit <= acc_wdata & rtps_pkg::LOCK_LIMIT_REG_STORE;
      end
   end

   // Load-done flag: a finishing load beats a loader reset in one cycle
   // Reset value is one, so a part with no loader reads as done
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         load_done <= rtps_pkg::LOAD_DONE_RESET;
      else if (clk_en)
      begin
         if (eeprom_load_done)
            load_done <= 1'b1;
         else if (loader_rst_req)
            load_done <= 1'b0;
      end
   end

   // Control outputs follow their register fields
   assign ref_freq_sel           = ref_frequency_select[rtps_pkg::REF_SEL_MSB:rtps_pkg::REF_SEL_LSB];
   assign divided_ref_out_select = shared_reset_and_sequencer_ctrl[rtps_pkg::DIV_REF_OUT_BIT];
   assign lock_sequencer_disable = shared_reset_and_sequencer_ctrl[rtps_pkg::LOCK_SEQ_DIS_BIT];

   // Limit passes through as written; the sequencer decides what 0 means
   assign concurrent_lock_limit  =
      load_status_and_lock_limit[rtps_pkg::LOCK_LIMIT_MSB:rtps_pkg::LOCK_LIMIT_LSB];

   // One-cycle action pulses; they hold while the clock enable is low
   // A frozen enable stretches them, so the consumer must gate with it too
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         shared_page_soft_reset   <= 1'b0;
         loader_master_soft_reset <= 1'b0;
         crc_trigger              <= 1'b0;
      end
      else if (clk_en)
      begin
         shared_page_soft_reset   <= shared_rst_req;
         loader_master_soft_reset <= loader_rst_req;
         crc_trigger              <= crc_req & ~shared_rst_req;
      end
   end

   // Channel page write: one strobe carries the routed mask
   // An empty mask gives no strobe, so the pages never see a stray write
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chan_wr      <= 1'b0;
         chan_wr_mask <= 16'h0000;
      end
      else if (clk_en)
      begin
         chan_wr      <= wr_take & to_chan & (route_mask != 16'h0000);
         chan_wr_mask <= (wr_take & to_chan) ? route_mask : 16'h0000;
      end
   end

   // Channel address and data shared by read and write strobes
   // Held between requests so the far side sees a steady address
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chan_addr  <= 8'h00;
         chan_wdata <= 8'h00;
      end
      else if ((wr_take | rd_take) & to_chan)
      begin
         chan_addr  <= acc_addr;
         chan_wdata <= acc_wdata;
      end
   end

   // Read path: local data in one cycle, a lone channel in two
   // Read data holds between answers; only the valid strobe marks new data
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_pend       <= 1'b0;
         chan_rd       <= 1'b0;
         chan_rd_index <= 4'h0;
         acc_rdata     <= 8'h00;
         acc_rvalid    <= 1'b0;
      end
      else if (clk_en)
      begin
         if (rd_pend)
         begin
            rd_pend    <= 1'b0;
            chan_rd    <= 1'b0;
            acc_rdata  <= chan_rdata;
            acc_rvalid <= 1'b1;
         end
         else if (rd_take && to_chan && route_single)
         begin
            rd_pend       <= 1'b1;
            chan_rd       <= 1'b1;
            chan_rd_index <= route_index;
            acc_rvalid    <= 1'b0;
         end
         // Zero selected channels also lands here and reads zero
         else if (rd_take)
         begin
            // Ambiguous channel reads answer zero rather than mix channels
            acc_rdata  <= to_chan ? rtps_pkg::READ_ZERO : local_rdata;
            acc_rvalid <= 1'b1;
         end
         else
            acc_rvalid <= 1'b0;
      end
   end

   // Busy mirrors the pending channel read
   assign acc_busy = rd_pend;
endmodule
`default_nettype wire

// File: verif/rtps_chan_model.sv
// Behavioural channel register pages on the far side of the bank
`default_nettype none
module rtps_chan_model (
   // Clock
   input  wire logic        clk,
   // Channel page requests
   input  wire logic        chan_wr,
   input  wire logic [15:0] chan_wr_mask,
   input  wire logic        chan_rd,
   input  wire logic [3:0]  chan_rd_index,
   input  wire logic [7:0]  chan_addr,
   input  wire logic [7:0]  chan_wdata,
   // Read answer
   output logic      [7:0]  chan_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [16][256];
   logic [7:0] junk;
   // Seed each byte with its channel and low address nibble
   initial
   begin
      for (int c = 0; c < 16; c++)
         for (int a = 0; a < 256; a++)
            mem[c][a] = {c[3:0], a[3:0]};
      junk = 8'h5A;
   end
   // Every page in the mask takes the byte, so broadcast lands everywhere
   always @(posedge clk)
   begin
      junk <= ~junk;
      if (chan_wr)
         for (int c = 0; c < 16; c++)
            if (chan_wr_mask[c])
               mem[c][chan_addr] <= chan_wdata;
   end
   // Toggling pattern outside a read, so a late sample never looks right
   assign chan_rdata = chan_rd ? mem[chan_rd_index][chan_addr] : junk;
endmodule
`default_nettype wire

// File: verif/rtps_shared_regs_chk.sv
// Concurrent checks on the page-select and shared register bank ports
`default_nettype none
module rtps_shared_regs_chk (
   // Clock and access port
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic [7:0]  acc_addr,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic        acc_wr,
   input  wire logic        acc_rd,
   input  wire logic [7:0]  acc_rdata,
   input  wire logic        acc_rvalid,
   input  wire logic        acc_busy,
   // Channel page side
   input  wire logic        chan_wr,
   input  wire logic [15:0] chan_wr_mask,
   input  wire logic        chan_rd,
   input  wire logic [3:0]  chan_rd_index,
   input  wire logic [7:0]  chan_rdata,
   // Device controls
   input  wire logic [6:0]  bus_address,
   input  wire logic [1:0]  ref_freq_sel,
   input  wire logic        divided_ref_out_select,
   input  wire logic        lock_sequencer_disable,
   input  wire logic [3:0]  concurrent_lock_limit,
   input  wire logic        shared_page_soft_reset,
   input  wire logic        loader_master_soft_reset,
   input  wire logic        crc_trigger
);
   logic [1:0]  pg;
   logic [15:0] sel;
   logic [7:0]  wd_q;
   logic        tw;
   logic        tr;
   logic        ch;
   // Taken requests and page decode; a write beats a read
   assign tw = clk_en && !acc_busy && acc_wr;
   assign tr = clk_en && !acc_busy && acc_rd && !acc_wr;
   assign ch = pg[0] && acc_addr != 8'hFC && acc_addr != 8'hFD && acc_addr != 8'hFF;
   // Mirror of the global selects; soft resets leave them alone
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pg  <= 2'h0;
         sel <= 16'h0000;
         wd_q <= 8'h00;
      end
      else
      begin
         wd_q <= acc_wdata;
         if (tw && acc_addr == 8'hFF)
            pg <= acc_wdata[1:0];
         if (tw && acc_addr == 8'hFC)
            sel[7:0] <= acc_wdata;
         if (tw && acc_addr == 8'hFD)
            sel[15:8] <= acc_wdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   bcast_write_a: assert property (tw && ch && pg == 2'h3 |=> chan_wr && chan_wr_mask == 16'hFFFF)
      else $error("broadcast write missed channels");
   sel_write_a: assert property (tw && ch && pg == 2'h1 && sel != 16'h0000 |=> chan_wr && chan_wr_mask == sel)
      else $error("channel write mask differs from selection");
   shared_page_a: assert property (tw && !ch |=> !chan_wr)
      else $error("shared or global write leaked to channels");
   multi_read_a: assert property (tr && ch && !$onehot(sel) |=> acc_rvalid && !chan_rd && acc_rdata == 8'h00)
      else $error("ambiguous channel read not zero");
   single_read_a: assert property (tr && ch && $onehot(sel) |=> chan_rd && sel[chan_rd_index] && acc_busy
      ##1 acc_rvalid && acc_rdata == $past(chan_rdata)) else $error("single channel read wrong");
   global_read_a: assert property (tr && acc_addr == 8'hFF |=> acc_rvalid && acc_rdata == {6'h00, pg})
      else $error("page select read back wrong");
   strap_addr_a: assert property (tr && !pg[0] && acc_addr == 8'h00
      |=> acc_rvalid && acc_rdata[3:0] == 4'h0 && bus_address == 7'h18 + acc_rdata[7:4]) else $error("strap report wrong");
   freq_write_a: assert property (tw && !pg[0] && acc_addr == 8'h02 |=> ref_freq_sel == wd_q[6:5])
      else $error("reference frequency not stored");
   ctrl_write_a: assert property (tw && !pg[0] && acc_addr == 8'h04 && !acc_wdata[6]
      |=> lock_sequencer_disable == wd_q[3] && divided_ref_out_select == wd_q[7] && loader_master_soft_reset == wd_q[5]
      ##1 !loader_master_soft_reset) else $error("control write wrong");
   soft_reset_a: assert property (tw && !pg[0] && acc_addr == 8'h04 && acc_wdata[6]
      |=> shared_page_soft_reset && !crc_trigger && ref_freq_sel == 2'h0 && concurrent_lock_limit == 4'h8
      && !lock_sequencer_disable ##1 !shared_page_soft_reset) else $error("shared soft reset wrong");
   limit_write_a: assert property (tw && !pg[0] && acc_addr == 8'h05
      |=> crc_trigger == wd_q[6] && concurrent_lock_limit == wd_q[3:0]) else $error("limit or trigger wrong");
endmodule
`default_nettype wire

// File: verif/rtps_shared_regs_tb.sv
// Self-checking bench for the page-select and shared register bank
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error at %0t ns: got %h, expected %h", $time, g, e); end end
module rtps_shared_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, eeprom_load_done = 1'b0, acc_wr = 1'b0, acc_rd = 1'b0;
   logic [3:0] addr_strap = 4'h9;
   logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, acc_rdata, chan_addr, chan_wdata, chan_rdata;
   logic acc_rvalid, acc_busy, chan_wr, chan_rd, divided_ref_out_select, lock_sequencer_disable;
   logic shared_page_soft_reset, loader_master_soft_reset, crc_trigger;
   logic [15:0] chan_wr_mask;
   logic [3:0] chan_rd_index, concurrent_lock_limit;
   logic [6:0] bus_address;
   logic [1:0] ref_freq_sel;
   int n_mismatch = 0;
   int total_checks = 0;
   // Identity parameters are arbitrary
   rtps_shared_regs #(.VERSION_CODE(3'h5), .PART_CODE(5'h13)) dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .addr_strap(addr_strap), .eeprom_load_done(eeprom_load_done), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
      .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .acc_busy(acc_busy),
      .chan_wr(chan_wr), .chan_wr_mask(chan_wr_mask), .chan_rd(chan_rd), .chan_rd_index(chan_rd_index),
      .chan_addr(chan_addr), .chan_wdata(chan_wdata), .chan_rdata(chan_rdata), .bus_address(bus_address),
      .ref_freq_sel(ref_freq_sel), .divided_ref_out_select(divided_ref_out_select),
      .lock_sequencer_disable(lock_sequencer_disable), .concurrent_lock_limit(concurrent_lock_limit),
      .shared_page_soft_reset(shared_page_soft_reset), .loader_master_soft_reset(loader_master_soft_reset),
      .crc_trigger(crc_trigger));
   rtps_chan_model far (.clk(clk), .chan_wr(chan_wr), .chan_wr_mask(chan_wr_mask), .chan_rd(chan_rd),
      .chan_rd_index(chan_rd_index), .chan_addr(chan_addr), .chan_wdata(chan_wdata), .chan_rdata(chan_rdata));
   // Clock at 100 MHz
   always #5 clk = ~clk;
   task automatic print_verdict();
      $display("Checks made: %0d, mismatches: %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Write pulse held over one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      acc_addr = a;
      acc_wdata = d;
      acc_wr = 1'b1;
      @(negedge clk);
      acc_wr = 1'b0;
   endtask
   // Read, then wait a bounded time for the answer strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int i;
      @(negedge clk);
      acc_addr = a;
      acc_rd = 1'b1;
      @(negedge clk);
      acc_rd = 1'b0;
      i = 0;
      while (acc_rvalid !== 1'b1 && i < 4)
      begin
         @(negedge clk);
         i++;
      end
      if (acc_rvalid !== 1'b1)
      begin
         n_mismatch++;
         $display("Error at %0t ns: no read answer", $time);
      end
      else
         `CHK(acc_rdata, e)
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      rd(8'hFF, 8'h00);
      rd(8'hFC, 8'h00);
      rd(8'hFD, 8'h00);
      rd(8'h02, 8'h00);
      rd(8'h04, 8'h01);
      rd(8'h05, 8'h18);
      rd(8'h01, 8'hB3);
      rd(8'h03, 8'h00);
      rd(8'h40, 8'h00);
      rd(8'h00, 8'h90);
      `CHK(bus_address, 7'h21)
      wr(8'hFF, 8'hFF);
      rd(8'hFF, 8'h03);
      wr(8'hFF, 8'h00);
      // Every frequency code, the reserved one too
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h02, {1'b0, k[1:0], 5'h00});
         `CHK(ref_freq_sel, k[1:0])
         rd(8'h02, {1'b0, k[1:0], 5'h00});
      end
      // Frozen enable must drop the write
      clk_en = 1'b0;
      wr(8'h02, 8'h20);
      clk_en = 1'b1;
      `CHK(ref_freq_sel, 2'h3)
      wr(8'h04, 8'h88);
      `CHK({divided_ref_out_select, lock_sequencer_disable}, 2'h3)
      rd(8'h04, 8'h88);
      wr(8'h05, 8'h43);
      `CHK({crc_trigger, concurrent_lock_limit}, 5'h13)
      rd(8'h05, 8'h53);
      wr(8'h04, 8'h20);
      `CHK(loader_master_soft_reset, 1'b1)
      rd(8'h04, 8'h00);
      rd(8'h05, 8'h43);
      @(negedge clk);
      eeprom_load_done = 1'b1;
      @(negedge clk);
      eeprom_load_done = 1'b0;
      rd(8'h05, 8'h53);
      wr(8'h04, 8'h40);
      `CHK({shared_page_soft_reset, ref_freq_sel, concurrent_lock_limit}, 7'h48)
      rd(8'h04, 8'h01);
      rd(8'h05, 8'h18);
      // Channel pages through the far-side model
      wr(8'hFF, 8'h01);
      wr(8'hFC, 8'h05);
      wr(8'hFD, 8'h80);
      rd(8'hFC, 8'h05);
      wr(8'h20, 8'h5A);
      `CHK({chan_wr, chan_wr_mask, chan_addr, chan_wdata}, {1'b1, 16'h8005, 8'h20, 8'h5A})
      wr(8'h02, 8'h40);
      `CHK(ref_freq_sel, 2'h0)
      rd(8'h20, 8'h00);
      wr(8'hFC, 8'h00);
      rd(8'h20, 8'h5A);
      wr(8'hFD, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h21, 8'h77);
      `CHK(chan_wr, 1'b0)
      wr(8'hFC, 8'h04);
      rd(8'h21, 8'h21);
      wr(8'hFF, 8'h03);
      wr(8'h21, 8'hC3);
      `CHK({chan_wr, chan_wr_mask}, {1'b1, 16'hFFFF})
      rd(8'h21, 8'hC3);
      wr(8'hFF, 8'h02);
      wr(8'h21, 8'h11);
      `CHK(chan_wr, 1'b0)
      rd(8'h02, 8'h00);
      print_verdict();
   end
endmodule
bind rtps_shared_regs rtps_shared_regs_chk chk (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_rdata(acc_rdata),
   .acc_rvalid(acc_rvalid), .acc_busy(acc_busy), .chan_wr(chan_wr), .chan_wr_mask(chan_wr_mask),
   .chan_rd(chan_rd), .chan_rd_index(chan_rd_index), .chan_rdata(chan_rdata), .bus_address(bus_address),
   .ref_freq_sel(ref_freq_sel), .divided_ref_out_select(divided_ref_out_select),
   .lock_sequencer_disable(lock_sequencer_disable), .concurrent_lock_limit(concurrent_lock_limit),
   .shared_page_soft_reset(shared_page_soft_reset), .loader_master_soft_reset(loader_master_soft_reset),
   .crc_trigger(crc_trigger));
`default_nettype wire
